// file: rtl/pwm_timer.v
/*
 * main pwm timer with three compare channels and an axi4-lite register slave.
 * assumes one 100 mhz clock; external timer input and position/overcurrent
 * inputs are asynchronous pins and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_consts.vh"

// How it works
// - input select 00 clocks timer from prescaler plus optional divide-by-256.
// - prescaler held cleared while run bit is zero.
// - clock select n divides by 2**n; extra divider multiplies by 256.
// - input select 01 counts one step per software count-pulse write.
// - input select 10/11 counts on rising/falling external input edges.
// - edge-aligned counts up, clears after period match; period is value+1.
// - center-aligned period match while up sets direction down next clock.
// - center-aligned count 0001 while down sets direction up next clock.
// - direction changes one timer clock after match; one step old direction.
// - single-shot bit clears run bit when current period completes.
// - edge-aligned single-shot stops as counter wraps to zero.
// - center-aligned single-shot stops when counting down reaches zero.
// - channels compare with active value loaded from shadow on transfer.
// - compare-driven state changes only while run bit is one.
// - state sets after up-count compare match, or zero plus compare match.
// - state clears after down-count match, or zero match without compare.
// - software forces state bits set or clear via state-modify register.
// - rising event on up-count match, falling on down-count match.
// - mode 1001 holds state zero while position input is zero.
// - position inputs sampled on module clock; ignored in normal mode.
// - period reads return active value; writes go to shadow.
// - zero match at 0000, one match at 0001.
// - counter writes ignored while running, immediate while stopped.
module pwm_timer #(
  parameter WIDTH = 16
) (
  // clock and reset
  input  wire              i_clk,
  input  wire              i_rst_n,
  // axi4-lite slave
  input  wire [7:0]        i_awaddr,
  input  wire              i_awvalid,
  output wire              o_awready,
  input  wire [31:0]       i_wdata,
  input  wire [3:0]        i_wstrb,
  input  wire              i_wvalid,
  output wire              o_wready,
  output reg  [1:0]        o_bresp,
  output reg               o_bvalid,
  input  wire              i_bready,
  input  wire [7:0]        i_araddr,
  input  wire              i_arvalid,
  output wire              o_arready,
  output reg  [31:0]       o_rdata,
  output reg  [1:0]        o_rresp,
  output reg               o_rvalid,
  input  wire              i_rready,
  // pins
  input  wire              i_external_timer_input,
  input  wire [2:0]        i_position_overcurrent_input,
  // status out
  output wire [2:0]        o_channel_state_bit,
  output reg  [2:0]        o_rising_compare_event,
  output reg  [2:0]        o_falling_compare_event,
  output wire              o_timer_run_bit,
  output wire              o_count_direction_flag
);

  // ==================================================================
  // registers
  reg  [2:0]       clock_divide_select;
  reg              extra_divider_enable;
  reg              align_mode_bit;
  reg              single_shot_bit;
  reg  [1:0]       timer_input_select;
  reg  [11:0]      channel_mode_register;
  reg  [WIDTH-1:0] period_active;
  reg  [WIDTH-1:0] period_shadow;
  reg  [WIDTH-1:0] active_compare_value [0:2];
  reg  [WIDTH-1:0] shadow_compare_value [0:2];
  reg  [WIDTH-1:0] counter;
  reg              count_direction_flag;
  reg              timer_run_bit;
  reg  [2:0]       channel_state_bit;
  reg  [2:0]       rise_sticky;
  reg  [2:0]       fall_sticky;
  reg  [14:0]      prescaler;
  reg  [2:0]       ext_sync;
  reg  [2:0]       pos_s1;
  reg  [2:0]       pos_s2;
  reg  [2:0]       pos_s3;
  reg  [2:0]       pos_state;

  // ==================================================================
  // axi4-lite handshake: write taken when address and data both present
  reg              aw_held;
  reg              w_held;
  reg  [7:0]       aw_addr;
  reg  [31:0]      w_data;
  reg  [3:0]       w_strb;
  wire             aw_take = i_awvalid & ~aw_held & ~o_bvalid;
  wire             w_take  = i_wvalid & ~w_held & ~o_bvalid;
  wire             have_aw = aw_held | aw_take;
  wire             have_w  = w_held | w_take;
  wire             wr_go   = have_aw & have_w & ~o_bvalid;
  wire [7:0]       wr_addr = aw_held ? aw_addr : i_awaddr;
  wire [31:0]      wr_data = w_held ? w_data : i_wdata;
  wire [3:0]       wr_strb = w_held ? w_strb : i_wstrb;
  assign o_awready = ~aw_held & ~o_bvalid;
  assign o_wready  = ~w_held & ~o_bvalid;
  assign o_arready = ~o_rvalid;
  wire             rd_go   = i_arvalid & ~o_rvalid;

  wire wr_ctl   = wr_go & (wr_addr == `OFS_CONTROL);
  wire wr_cmd   = wr_go & (wr_addr == `OFS_CMD);
  wire wr_per   = wr_go & (wr_addr == `OFS_PERIOD);
  wire wr_cnt   = wr_go & (wr_addr == `OFS_COUNTER);
  wire wr_sm    = wr_go & (wr_addr == `OFS_STATE_MODIFY);
  wire wr_mode  = wr_go & (wr_addr == `OFS_MODE);
  wire wr_stat  = wr_go & (wr_addr == `OFS_STATUS);
  wire [2:0] wr_cmp;
  assign wr_cmp[0] = wr_go & (wr_addr == `OFS_COMPARE0);
  assign wr_cmp[1] = wr_go & (wr_addr == `OFS_COMPARE1);
  assign wr_cmp[2] = wr_go & (wr_addr == `OFS_COMPARE2);
  wire wr_known = wr_ctl | wr_cmd | wr_per | wr_cnt | wr_sm | wr_mode | wr_stat | (|wr_cmp);

  wire cmd_lane = wr_cmd & wr_strb[0];
  wire run_set  = cmd_lane & wr_data[`CMD_RUN_SET];
  wire run_clr  = cmd_lane & wr_data[`CMD_RUN_CLR];
  wire count_pulse_bit        = cmd_lane & wr_data[`CMD_COUNT];
  wire shadow_transfer_signal = cmd_lane & wr_data[`CMD_SHADOW];

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= 8'h00;
      w_data   <= 32'h0000_0000;
      w_strb   <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp  <= `AXI_OKAY;
    end else begin
      if (aw_take & ~wr_go) begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (w_take & ~wr_go) begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (wr_go) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= wr_known ? `AXI_OKAY : `AXI_SLVERR;
      end else if (o_bvalid & i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // ==================================================================
  // pin synchronisers: a change counts when the second and third stages agree
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      ext_sync  <= 3'h0;
      pos_s1    <= 3'h0;
      pos_s2    <= 3'h0;
      pos_s3    <= 3'h0;
      pos_state <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], i_external_timer_input};
      pos_s1   <= i_position_overcurrent_input;
      pos_s2   <= pos_s1;
      pos_s3   <= pos_s2;
      pos_state <= (pos_s2 & pos_s3) | (pos_state & (pos_s2 | pos_s3));
    end
  end
  reg ext_level;
  reg ext_prev;
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      ext_level <= 1'b0;
      ext_prev  <= 1'b0;
    end else begin
      if (ext_sync[1] == ext_sync[2])
        ext_level <= ext_sync[2];
      ext_prev <= ext_level;
    end
  end

  // ==================================================================
  // timer clock enable selection
  wire [14:0] pre_mask = ((15'h0001 << clock_divide_select)
                          << (extra_divider_enable ? `PRE_EXTRA_BITS : 0)) - 15'h0001;
  wire pre_tick = ((prescaler & pre_mask) == pre_mask);
  reg  timer_tick;
  always @* begin
    case (timer_input_select)
      `INSEL_TIMER: timer_tick = pre_tick;
      `INSEL_SOFT:  timer_tick = count_pulse_bit;
      `INSEL_RISE:  timer_tick = ext_level & ~ext_prev;
      `INSEL_FALL:  timer_tick = ~ext_level & ext_prev;
      default:      timer_tick = 1'b0;
    endcase
  end
  // counting only while running
  wire step = timer_tick & timer_run_bit;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      prescaler <= 15'h0000;
    end else if (!timer_run_bit || pre_tick) begin
      prescaler <= 15'h0000;
    end else begin
      prescaler <= prescaler + 15'h0001;
    end
  end

  // ==================================================================
  // counter, direction and run bit
  // zero and one matches
  wire zero_match   = (counter == `RST_WORD16);
  wire one_match    = (counter == `ONE16);
  wire period_match = (counter == period_active);

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      counter              <= `RST_WORD16;
      count_direction_flag <= 1'b0;
      timer_run_bit        <= 1'b0;
    end else begin
      if (run_set)
        timer_run_bit <= 1'b1;
      else if (run_clr)
        timer_run_bit <= 1'b0;
      if (wr_cnt && !timer_run_bit) begin
        counter <= wr_data[WIDTH-1:0];
      end else if (step) begin
        if (!align_mode_bit) begin
          count_direction_flag <= 1'b0;
          if (period_match) begin
            counter <= `RST_WORD16;
            if (single_shot_bit)
              timer_run_bit <= 1'b0;
          end else begin
            counter <= counter + `ONE16;
          end
        end else begin
          counter <= count_direction_flag ? counter - `ONE16 : counter + `ONE16;
          if (!count_direction_flag && period_match)
            count_direction_flag <= 1'b1;
          if (count_direction_flag && one_match) begin
            count_direction_flag <= 1'b0;
            if (single_shot_bit)
              timer_run_bit <= 1'b0;
          end
        end
      end
    end
  end

  // ==================================================================
  // compare channels
  wire [2:0] channel_match_signal;
  reg  [2:0] next_state;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : chan
      assign channel_match_signal[g] = (counter == active_compare_value[g]);
    end
  endgenerate
  integer k;
  integer j;
  always @* begin
    next_state = channel_state_bit;
    for (k = 0; k < 3; k = k + 1) begin
      if (step) begin
        if (!count_direction_flag && channel_match_signal[k])
          next_state[k] = 1'b1;
        else if (count_direction_flag && channel_match_signal[k])
          next_state[k] = 1'b0;
        else if (!count_direction_flag && zero_match)
          next_state[k] = 1'b0;
      end
      if (wr_sm && wr_data[k])
        next_state[k] = 1'b1;
      if (wr_sm && wr_data[`SM_CLR_LSB + k])
        next_state[k] = 1'b0;
      if (channel_mode_register[4*k +: 4] == `MODE_HYST && !pos_state[k])
        next_state[k] = 1'b0;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      channel_state_bit       <= 3'h0;
      o_rising_compare_event  <= 3'h0;
      o_falling_compare_event <= 3'h0;
      rise_sticky             <= 3'h0;
      fall_sticky             <= 3'h0;
    end else begin
      channel_state_bit <= next_state;
      o_rising_compare_event  <= {3{step & ~count_direction_flag}} & channel_match_signal;
      o_falling_compare_event <= {3{step & count_direction_flag}} & channel_match_signal;
      // set wins over a write-one clear in the same cycle
      rise_sticky <= (rise_sticky & ~({3{wr_stat}} & wr_data[`ST_RISE_LSB +: 3]))
                   | ({3{step & ~count_direction_flag}} & channel_match_signal);
      fall_sticky <= (fall_sticky & ~({3{wr_stat}} & wr_data[`ST_FALL_LSB +: 3]))
                   | ({3{step & count_direction_flag}} & channel_match_signal);
    end
  end

  // ==================================================================
  // configuration and shadow registers
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      clock_divide_select   <= 3'h0;
      extra_divider_enable  <= 1'b0;
      align_mode_bit        <= 1'b0;
      single_shot_bit       <= 1'b0;
      timer_input_select    <= `INSEL_TIMER;
      channel_mode_register <= 12'h000;
      period_active         <= `RST_WORD16;
      period_shadow         <= `RST_WORD16;
      for (j = 0; j < 3; j = j + 1) begin
        active_compare_value[j] <= `RST_WORD16;
        shadow_compare_value[j] <= `RST_WORD16;
      end
    end else begin
      if (wr_ctl && wr_strb[0]) begin
        clock_divide_select  <= wr_data[`CTL_CLKSEL_LSB +: 3];
        extra_divider_enable <= wr_data[`CTL_PRE_BIT];
        align_mode_bit       <= wr_data[`CTL_ALIGN_BIT];
        single_shot_bit      <= wr_data[`CTL_SSHOT_BIT];
        timer_input_select   <= wr_data[`CTL_INSEL_LSB +: 2];
      end
      if (wr_mode)
        channel_mode_register <= wr_data[11:0];
      if (wr_per)
        period_shadow <= wr_data[WIDTH-1:0];
      for (j = 0; j < 3; j = j + 1) begin
        if (wr_cmp[j])
          shadow_compare_value[j] <= wr_data[WIDTH-1:0];
      end
      if (shadow_transfer_signal) begin
        period_active <= period_shadow;
        for (j = 0; j < 3; j = j + 1)
          active_compare_value[j] <= shadow_compare_value[j];
      end
    end
  end

  // ==================================================================
  // read channel, one cycle after the address is taken
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (i_araddr)
      `OFS_CONTROL:      rd_mux = {24'h000000, timer_input_select, single_shot_bit,
                                   align_mode_bit, extra_divider_enable, clock_divide_select};
      `OFS_PERIOD:       rd_mux = {16'h0000, period_active};
      `OFS_COUNTER:      rd_mux = {16'h0000, counter};
      `OFS_COMPARE0:     rd_mux = {16'h0000, shadow_compare_value[0]};
      `OFS_COMPARE1:     rd_mux = {16'h0000, shadow_compare_value[1]};
      `OFS_COMPARE2:     rd_mux = {16'h0000, shadow_compare_value[2]};
      `OFS_STATUS:       rd_mux = {17'h00000, fall_sticky, 1'b0, rise_sticky, 3'h0,
                                   timer_run_bit, count_direction_flag, channel_state_bit};
      `OFS_MODE:         rd_mux = {20'h00000, channel_mode_register};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end
  wire rd_known = (i_araddr == `OFS_CONTROL) | (i_araddr == `OFS_CMD) | (i_araddr == `OFS_PERIOD)
                | (i_araddr == `OFS_COUNTER) | (i_araddr == `OFS_COMPARE0) | (i_araddr == `OFS_COMPARE1)
                | (i_araddr == `OFS_COMPARE2) | (i_araddr == `OFS_STATE_MODIFY)
                | (i_araddr == `OFS_STATUS) | (i_araddr == `OFS_MODE);

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= `AXI_OKAY;
    end else if (rd_go) begin
      o_rvalid <= 1'b1;
      o_rdata  <= rd_mux;
      o_rresp  <= rd_known ? `AXI_OKAY : `AXI_SLVERR;
    end else if (o_rvalid & i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  assign o_channel_state_bit    = channel_state_bit;
  assign o_timer_run_bit        = timer_run_bit;
  assign o_count_direction_flag = count_direction_flag;

endmodule // pwm_timer
`default_nettype wire

// file: rtl/pwm_timer_consts.vh
/*
 * constants for the three-channel pwm timer: register offsets, field positions,
 * reset values and mode codes. assumes an axi4-lite slave with 32-bit data.
 */
`ifndef PWM_TIMER_CONSTS_VH
`define PWM_TIMER_CONSTS_VH

// ==================================================================
// register byte offsets
`define OFS_CONTROL      8'h00
`define OFS_CMD          8'h04
`define OFS_PERIOD       8'h08
`define OFS_COUNTER      8'h0c
`define OFS_COMPARE0     8'h10
`define OFS_COMPARE1     8'h14
`define OFS_COMPARE2     8'h18
`define OFS_STATE_MODIFY 8'h1c
`define OFS_STATUS       8'h20
`define OFS_MODE         8'h24

// ==================================================================
// control register fields
`define CTL_CLKSEL_LSB   0
`define CTL_PRE_BIT      3
`define CTL_ALIGN_BIT    4
`define CTL_SSHOT_BIT    5
`define CTL_INSEL_LSB    6

// command register bits (write-one pulses)
`define CMD_RUN_SET      0
`define CMD_RUN_CLR      1
`define CMD_COUNT        2
`define CMD_SHADOW       3

// state-modify register: set bits 0..2, clear bits 8..10
`define SM_CLR_LSB       8

// status register fields
`define ST_STATE_LSB     0
`define ST_DIR_BIT       3
`define ST_RUN_BIT       4
`define ST_RISE_LSB      8
`define ST_FALL_LSB      12

// ==================================================================
// codes and reset values
`define INSEL_TIMER      2'h0
`define INSEL_SOFT       2'h1
`define INSEL_RISE       2'h2
`define INSEL_FALL       2'h3
`define MODE_HYST        4'h9
`define PRE_EXTRA_BITS   8
`define RST_WORD16       16'h0000
`define ONE16            16'h0001
`define AXI_OKAY         2'h0
`define AXI_SLVERR       2'h2

`endif

// file: test/pwm_pins_model.sv
/* pin model: external timer input and position/overcurrent comparators.
   assumes the bench calls its tasks from one process at a time. */
`timescale 1ns/1ps
`default_nettype none
module pwm_pins_model (
  // clock
  input  wire logic      i_clk,
  // pins towards the timer
  output var logic       o_external_timer_input,
  output var logic [2:0] o_position_overcurrent_input
);
  initial begin
    o_external_timer_input = 1'b0;
    o_position_overcurrent_input = 3'h7;
  end
  // ==========================================
  // pulses wide enough for the three-stage synchroniser
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (6) @(posedge i_clk);
      o_external_timer_input <= 1'b1;
      repeat (6) @(posedge i_clk);
      o_external_timer_input <= 1'b0;
    end
    repeat (6) @(posedge i_clk);
  endtask
  task automatic set_position(input logic [2:0] p);
    @(posedge i_clk);
    o_position_overcurrent_input <= p;
  endtask
endmodule // pwm_pins_model
`default_nettype wire

// file: test/pwm_timer_assertions.sv
/* port checker for pwm_timer: bus answers, refusals, events, run and direction.
   assumes one clock and the synchronous active-low reset of the timer. */
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_checker (
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  // register bus
  input wire logic       i_awvalid,
  input wire logic       o_awready,
  input wire logic       i_wvalid,
  input wire logic       o_wready,
  input wire logic       o_bvalid,
  input wire logic       i_arvalid,
  input wire logic       o_arready,
  input wire logic       o_rvalid,
  // timer status
  input wire logic [2:0] o_channel_state_bit,
  input wire logic [2:0] o_rising_compare_event,
  input wire logic [2:0] o_falling_compare_event,
  input wire logic       o_timer_run_bit,
  input wire logic       o_count_direction_flag
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ==========================================
  // bus handshakes
  sequence s_write_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_read_taken;
    i_arvalid && o_arready;
  endsequence
  property p_write_answer; s_write_taken |=> o_bvalid; endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered"); // bus
  property p_read_answer; s_read_taken |=> o_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered"); // bus
  // pending response blocks a second write
  property p_write_refused; o_bvalid |-> !o_awready && !o_wready; endproperty
  a_write_refused: assert property (p_write_refused) else $error("write taken under response"); // bus
  // ==========================================
  // timer behaviour
  property p_reset_clear; @(posedge i_clk) disable iff (1'b0)
    !i_rst_n |=> o_channel_state_bit == 3'h0 && !o_timer_run_bit && !o_count_direction_flag; endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state not clear");
  property p_no_double; (o_rising_compare_event & o_falling_compare_event) == 3'h0; endproperty
  a_no_double: assert property (p_no_double) else $error("rise and fall together");
  property p_rise_single; o_rising_compare_event != 3'h0 |=> (o_rising_compare_event & $past(o_rising_compare_event)) == 3'h0; endproperty
  a_rise_single: assert property (p_rise_single) else $error("rise event too long");
  // events only come from steps, and steps only while running
  property p_event_needs_run; (o_rising_compare_event | o_falling_compare_event) != 3'h0
    |-> $past(o_timer_run_bit) || $past(o_timer_run_bit, 2); endproperty
  a_event_needs_run: assert property (p_event_needs_run) else $error("event while stopped");
  property p_dir_steps; $changed(o_count_direction_flag) |-> $past(o_timer_run_bit); endproperty
  a_dir_steps: assert property (p_dir_steps) else $error("direction moved while stopped");
endmodule // pwm_timer_checker

bind pwm_timer pwm_timer_checker chk (
  .i_clk, .i_rst_n, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_arvalid, .o_arready, .o_rvalid,
  .o_channel_state_bit, .o_rising_compare_event, .o_falling_compare_event, .o_timer_run_bit, .o_count_direction_flag
);
`default_nettype wire

// file: test/pwm_timer_tb.sv
/* self-checking bench for pwm_timer: axi4-lite master tasks, pin model, one task per scenario.
   assumes the rtl folder is on the include path for the register constants. */
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_consts.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("Error %s expected %h seen %h", nm, e, g); end end
module pwm_timer_tb;
  // ==========================================
  // signals
  logic        i_clk     = 1'b0;
  logic        i_rst_n   = 1'b0;
  logic [7:0]  i_awaddr  = 8'h00;
  logic        i_awvalid = 1'b0;
  logic [31:0] i_wdata   = 32'h0;
  logic [3:0]  i_wstrb   = 4'h0;
  logic        i_wvalid  = 1'b0;
  logic        i_bready  = 1'b0;
  logic [7:0]  i_araddr  = 8'h00;
  logic        i_arvalid = 1'b0;
  logic        i_rready  = 1'b0;
  wire         o_awready;
  wire         o_wready;
  wire  [1:0]  o_bresp;
  wire         o_bvalid;
  wire         o_arready;
  wire  [31:0] o_rdata;
  wire  [1:0]  o_rresp;
  wire         o_rvalid;
  wire         i_external_timer_input;
  wire  [2:0]  i_position_overcurrent_input;
  wire  [2:0]  o_channel_state_bit;
  wire  [2:0]  o_rising_compare_event;
  wire  [2:0]  o_falling_compare_event;
  wire         o_timer_run_bit;
  wire         o_count_direction_flag;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          run_cnt = 0;
  int          run_len = 0;
  int          dir_cnt = 0;
  int          dir_len = 0;
  logic [31:0] rdat;
  logic [1:0]  resp;
  pwm_timer dut (
    .i_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
    .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
    .i_rready, .i_external_timer_input, .i_position_overcurrent_input, .o_channel_state_bit,
    .o_rising_compare_event, .o_falling_compare_event, .o_timer_run_bit, .o_count_direction_flag
  );
  pwm_pins_model pins (
    .i_clk,
    .o_external_timer_input(i_external_timer_input),
    .o_position_overcurrent_input(i_position_overcurrent_input)
  );
  always #5 i_clk = ~i_clk;
  // ==========================================
  // run and direction lengths, sampled off the active edge
  always @(negedge i_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      test_done();
    end
    if (o_timer_run_bit === 1'b1) run_cnt++;
    else if (run_cnt != 0) begin
      run_len = run_cnt;
      run_cnt = 0;
    end
    if (o_count_direction_flag === 1'b1) dir_cnt++;
    else if (dir_cnt != 0) begin
      dir_len = dir_cnt;
      dir_cnt = 0;
    end
  end
  // ==========================================
  // bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    logic hb;
    i_awaddr  <= a;
    i_wdata   <= d;
    i_wstrb   <= 4'hf;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = o_awready;
      tw = o_wready;
      @(posedge i_clk);
      if (ta) i_awvalid <= 1'b0;
      if (tw) i_wvalid <= 1'b0;
    end while ((i_awvalid && !ta) || (i_wvalid && !tw));
    do begin
      @(negedge i_clk);
      hb = o_bvalid;
      resp = o_bresp;
      @(posedge i_clk);
    end while (!hb);
    i_bready <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic t;
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    do begin
      @(negedge i_clk);
      t = o_arready;
      @(posedge i_clk);
    end while (!t);
    i_arvalid <= 1'b0;
    do begin
      @(negedge i_clk);
      t = o_rvalid;
      rdat = o_rdata;
      resp = o_rresp;
      @(posedge i_clk);
    end while (!t);
    i_rready <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK($sformatf("reg %h", a), e, rdat)
  endtask
  task automatic wait_run();
    while (run_len == 0) @(posedge i_clk);
  endtask
  // ==========================================
  // scenarios
  task automatic s_reset();
    `CHK("outputs", 11'h0, {o_channel_state_bit, o_rising_compare_event, o_falling_compare_event, o_timer_run_bit, o_count_direction_flag})
    rd_chk(`OFS_STATUS, 32'h0);
    rd_chk(`OFS_CONTROL, 32'h0);
    wr(8'h28, 32'h1);
    `CHK("bresp", `AXI_SLVERR, resp)
    rd(8'h28);
    `CHK("rresp", {`AXI_SLVERR, 32'h0}, {resp, rdat})
    wr(`OFS_PERIOD, 32'h3);
    rd_chk(`OFS_PERIOD, 32'h0);
    wr(`OFS_CMD, 32'h8);
    rd_chk(`OFS_PERIOD, 32'h3);
  endtask
  task automatic s_prescale();
    for (int n = 0; n < 10; n++) begin
      wr(`OFS_CONTROL, 32'h20 | n);
      if (n == 9) begin
        wr(`OFS_CMD, 32'h1);
        wr(`OFS_CMD, 32'h2);
        wr(`OFS_COUNTER, 32'h0);
      end
      run_len = 0;
      wr(`OFS_CMD, 32'h1);
      wait_run();
      `CHK("run length", 4 << n, run_len)
    end
  endtask
  task automatic s_center();
    wr(`OFS_CONTROL, 32'h30);
    wr(`OFS_COMPARE0, 32'h2);
    wr(`OFS_CMD, 32'h8);
    wr(`OFS_STATUS, 32'h7700);
    run_len = 0;
    dir_len = 0;
    wr(`OFS_CMD, 32'h1);
    wait_run();
    `CHK("run length", 8, run_len)
    `CHK("down length", 4, dir_len)
    rd_chk(`OFS_STATUS, 32'h1706);
  endtask
  task automatic s_soft();
    wr(`OFS_CONTROL, 32'h40);
    wr(`OFS_PERIOD, 32'h4);
    wr(`OFS_COMPARE0, 32'h2);
    wr(`OFS_COMPARE1, 32'h0);
    wr(`OFS_COMPARE2, 32'h5);
    wr(`OFS_CMD, 32'h8);
    wr(`OFS_CMD, 32'h1);
    for (int k = 1; k < 7; k++) begin
      wr(`OFS_CMD, 32'h4);
      rd_chk(`OFS_COUNTER, k % 5);
      `CHK("states", {2'b01, (k % 5 >= 3) || (k % 5 == 0)}, o_channel_state_bit)
    end
    wr(`OFS_COUNTER, 32'h9);
    rd_chk(`OFS_COUNTER, 32'h1);
    wr(`OFS_CMD, 32'h2);
    wr(`OFS_COUNTER, 32'h2);
    wr(`OFS_CMD, 32'h4);
    rd_chk(`OFS_COUNTER, 32'h2);
    `CHK("states", 3'b010, o_channel_state_bit)
  endtask
  task automatic s_ext();
    wr(`OFS_PERIOD, 32'h9);
    wr(`OFS_CMD, 32'h8);
    wr(`OFS_CONTROL, 32'h80);
    wr(`OFS_COUNTER, 32'h0);
    wr(`OFS_CMD, 32'h1);
    pins.pulse(2);
    rd_chk(`OFS_COUNTER, 32'h2);
    wr(`OFS_CMD, 32'h2);
    wr(`OFS_CONTROL, 32'hc0);
    wr(`OFS_CMD, 32'h1);
    pins.pulse(3);
    rd_chk(`OFS_COUNTER, 32'h5);
    wr(`OFS_CMD, 32'h2);
  endtask
  task automatic s_force_hyst();
    wr(`OFS_STATE_MODIFY, 32'h7);
    `CHK("states", 3'b111, o_channel_state_bit)
    wr(`OFS_STATE_MODIFY, 32'h200);
    `CHK("states", 3'b101, o_channel_state_bit)
    wr(`OFS_STATE_MODIFY, 32'h404);
    `CHK("states", 3'b001, o_channel_state_bit)
    // hysteresis hold on channel zero; synchroniser needs a few clocks
    wr(`OFS_MODE, 32'h9);
    pins.set_position(3'b000);
    repeat (8) @(posedge i_clk);
    `CHK("states", 3'b000, o_channel_state_bit)
    wr(`OFS_STATE_MODIFY, 32'h7);
    `CHK("states", 3'b110, o_channel_state_bit)
    pins.set_position(3'b001);
    repeat (8) @(posedge i_clk);
    wr(`OFS_STATE_MODIFY, 32'h7);
    `CHK("states", 3'b111, o_channel_state_bit)
    pins.set_position(3'b000);
    repeat (8) @(posedge i_clk);
    `CHK("states", 3'b110, o_channel_state_bit)
  endtask
  // ==========================================
  // sequence and verdict
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    s_reset();
    s_prescale();
    s_center();
    s_soft();
    s_ext();
    s_force_hyst();
    test_done();
  end
endmodule // pwm_timer_tb
`default_nettype wire
